// *** logic/motion_engine_pkg.sv ***
// constants for the motion engine register bank
`default_nettype none
package motion_engine_pkg;
	localparam int ADDR_W = 12;

	localparam logic [ADDR_W-1:0] ENGINE_ENABLE_KEY_OFS       = 12'h100;
	localparam logic [ADDR_W-1:0] MOTION_SENSITIVITY_OFS      = 12'h101;
	localparam logic [ADDR_W-1:0] MOTION_STATUS_CONTROL0_OFS  = 12'h102;
	localparam logic [ADDR_W-1:0] ENGINE_STATUS_CONTROL1_OFS  = 12'h103;
	localparam logic [ADDR_W-1:0] RANGE_CONTROL2_OFS          = 12'h104;
	localparam logic [ADDR_W-1:0] ADC_SCAN_REQUEST3_OFS       = 12'h105;
	localparam logic [ADDR_W-1:0] ADC_SCAN_RESULT_LO_OFS      = 12'h10a;
	localparam logic [ADDR_W-1:0] ADC_SCAN_RESULT_HI_OFS      = 12'h10b;
	localparam logic [ADDR_W-1:0] ENGINE_SOFTWARE_VERSION_OFS = 12'h10c;

	localparam logic [7:0] ENGINE_OFF_KEY = 8'h00;
	localparam logic [7:0] ENGINE_ON_KEY  = 8'h11;

	// motion_status_control0 field positions
	localparam int SC0_EXT_HI    = 7;
	localparam int SC0_EXT_LO    = 6;
	localparam int SC0_DISABLED  = 5;
	localparam int SC0_SUSPEND   = 4;
	localparam int SC0_DIR_CTRL  = 3;
	localparam int SC0_DIRECTION = 2;
	localparam int SC0_MOTION    = 1;
	localparam int SC0_STABLE    = 0;

	// engine_status_control1 one-second tick bit
	localparam int SC1_TICK = 7;

	// range field of range_control2 that stretches the duration check
	localparam int RANGE_HI = 3;
	localparam int RANGE_LO = 0;

	localparam logic [7:0] REG_RESET  = 8'h00;
	localparam logic [7:0] READ_EMPTY = 8'h00;
	localparam int         THR_W      = 10;
	localparam int         RUN_W      = 10;
endpackage
`default_nettype wire

// *** logic/motion_qualifier.sv ***
// run-length check that accepts a motion signal once it lasts long enough
`default_nettype none
module motion_qualifier #(
	parameter int THR_W = 10,
	parameter int RUN_W = 10
) (
	// clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             clear_i,
	input  wire logic             step_i,
	input  wire logic             motion_raw_i,
	input  wire logic [THR_W-1:0] threshold_i,
	// result
	output logic                  accept_o
);
	logic [RUN_W-1:0] run;
	logic             done;

	// run counts consecutive samples with the raw signal high
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			run  <= '0;
			done <= 1'b0;
		end else if (clear_i) begin
			run  <= '0;
			done <= 1'b0;
		end else if (step_i) begin
			if (!motion_raw_i) begin
				run  <= '0;
				done <= 1'b0;
			end else if (!done && run >= RUN_W'(threshold_i)) begin
				done <= 1'b1; // one event per continuous signal
			end else if (!done) begin
				run <= run + RUN_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			accept_o <= 1'b0;
		end else begin
			accept_o <= step_i && !clear_i && motion_raw_i && !done
				&& run >= RUN_W'(threshold_i);
		end
	end

	duration_met_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		accept_o |-> $past(run) >= RUN_W'($past(threshold_i)) && $past(motion_raw_i))
		else $error("motion accepted before its duration was reached");
endmodule
`default_nettype wire

// *** logic/motion_engine_regs.sv ***
// register bank and engine control of the passive infrared motion engine
//
// Behaviour
// - writing key 11h enables all primary detection functions per control registers
// - writing key 00h stops every function until the engine is enabled again
// - reading the enable register returns exactly the last written value
// - on enable, configuration is captured and engine status fields reset
// - engine disabled status shows in bit 5 of status control 0
// - sensitivity 00h is most sensitive, FFh least; no defined default
// - sensitivity sets the minimum duration a motion signal must last
// - lower sensitivity values extend range, higher values shorten it
// - status control 0 holds level, disabled, suspend, dir, motion, stable
// - two-bit extended level selects four levels catching subtler motion
// - extended level 00 least sensitive, 11 most sensitive
// - higher extended level weakens the effect of the range setting
// - adc result at 10Ah/10Bh, version at 10Ch, scan request at 105h
// - disable takes hold at the next adc interrupt, setting disabled bit
// - engine sets motion detected; a software write of zero or the next enable clears it
// - suspend stops detection, sampling goes on; resume at next adc interrupt
`default_nettype none
module motion_engine_regs
	import motion_engine_pkg::*;
#(
	parameter logic [7:0] VERSION_CODE = 8'h01, // arbitrary value
	parameter int         ADC_W        = 16
) (
	// clock and reset
	input  wire logic                               core_clk_i,
	input  wire logic                               rst_i,
	// register port
	input  wire logic [motion_engine_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic                               reg_wr_i,
	input  wire logic [7:0]                         reg_wdata_i,
	input  wire logic                               reg_rd_i,
	output logic      [7:0]                         reg_rdata_o,
	// engine events
	input  wire logic                               engine_init_entry_i,
	input  wire logic                               adc_irq_i,
	input  wire logic [ADC_W-1:0]                   adc_data_i,
	// sensor front end
	input  wire logic                               motion_raw_i,
	input  wire logic                               motion_dir_i,
	input  wire logic                               sensor_stable_i,
	// status
	output logic                                    engine_running_o,
	output logic                                    motion_detected_o,
	output logic                                    detection_active_o
);
	import motion_engine_pkg::*;

	logic [7:0]       engine_enable_key;
	logic [7:0]       motion_sensitivity;
	logic [1:0]       ext_level;
	logic             engine_disabled;
	logic             detection_suspend;
	logic             dir_control;
	logic             direction;
	logic             motion;
	logic             stable;
	logic [7:0]       engine_status_control1;
	logic [7:0]       range_control2;
	logic [7:0]       adc_scan_request3;
	logic [ADC_W-1:0] adc_scan_result;
	logic             suspend_active;
	logic [7:0]       cfg_sens;
	logic [1:0]       cfg_ext;
	logic [3:0]       cfg_range;
	logic             cfg_dir;
	logic             accept;
	logic             enable_event;
	logic             disable_event;
	logic             step;
	logic             wr_key;
	logic             wr_sc0;
	logic             wr_sc1;
	logic [THR_W-1:0] threshold;
	logic [7:0]       next_rdata;

	// range weight shrinks with the extended level, level also trims the check
	function automatic logic [THR_W-1:0] duration_threshold(
		input logic [7:0] sens,
		input logic [3:0] range,
		input logic [1:0] ext
	);
		logic [THR_W-1:0] sum;
		sum = THR_W'(sens) + (THR_W'(range) >> ext);
		if (sum > THR_W'(ext)) begin
			duration_threshold = sum - THR_W'(ext);
		end else begin
			duration_threshold = '0;
		end
	endfunction

	assign wr_key = reg_wr_i && reg_addr_i == ENGINE_ENABLE_KEY_OFS;
	assign wr_sc0 = reg_wr_i && reg_addr_i == MOTION_STATUS_CONTROL0_OFS;
	assign wr_sc1 = reg_wr_i && reg_addr_i == ENGINE_STATUS_CONTROL1_OFS;

	// enabling happens at the init entry or at an interrupt with the on key held
	assign enable_event  = engine_disabled && engine_enable_key == ENGINE_ON_KEY
		&& (engine_init_entry_i || adc_irq_i);
	// disable only takes hold when the engine next runs, as in firmware
	assign disable_event = !engine_disabled && adc_irq_i
		&& engine_enable_key == ENGINE_OFF_KEY;
	assign step = adc_irq_i && !engine_disabled && !disable_event && !enable_event;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			engine_enable_key <= REG_RESET;
		end else if (wr_key) begin
			engine_enable_key <= reg_wdata_i; // stored as written
		end
	end

	// reserved keys match neither pattern, so no event fires
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			engine_disabled <= 1'b1;
		end else if (enable_event) begin
			engine_disabled <= 1'b0;
		end else if (disable_event) begin
			engine_disabled <= 1'b1;
		end
	end

	// application-controlled bytes; sensitivity has no documented default
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			motion_sensitivity <= REG_RESET;
			range_control2     <= REG_RESET;
			adc_scan_request3  <= REG_RESET;
		end else if (reg_wr_i) begin
			if (reg_addr_i == MOTION_SENSITIVITY_OFS) begin
				motion_sensitivity <= reg_wdata_i;
			end else if (reg_addr_i == RANGE_CONTROL2_OFS) begin
				range_control2 <= reg_wdata_i;
			end else if (reg_addr_i == ADC_SCAN_REQUEST3_OFS) begin
				adc_scan_request3 <= reg_wdata_i;
			end
		end
	end

	// tick: software sets, engine clears at its interrupt; a write wins
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			engine_status_control1 <= REG_RESET;
		end else if (wr_sc1) begin
			engine_status_control1 <= reg_wdata_i;
		end else if (step) begin
			engine_status_control1[SC1_TICK] <= 1'b0;
		end
	end

	// writable fields of status control 0
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_level         <= 2'h0;
			detection_suspend <= 1'b0;
			dir_control       <= 1'b0;
		end else if (wr_sc0) begin
			ext_level         <= reg_wdata_i[SC0_EXT_HI:SC0_EXT_LO];
			detection_suspend <= reg_wdata_i[SC0_SUSPEND];
			dir_control       <= reg_wdata_i[SC0_DIR_CTRL];
		end
	end

	// suspend is sampled when an interrupt runs and when the engine is enabled
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			suspend_active <= 1'b0;
		end else if (enable_event) begin
			suspend_active <= detection_suspend;
		end else if (adc_irq_i) begin
			suspend_active <= detection_suspend;
		end
	end

	// configuration seen by the engine, refreshed on enable and each run
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_sens  <= REG_RESET;
			cfg_ext   <= 2'h0;
			cfg_range <= 4'h0;
			cfg_dir   <= 1'b0;
		end else if (enable_event || step) begin
			cfg_sens  <= motion_sensitivity;
			cfg_ext   <= ext_level;
			cfg_range <= range_control2[RANGE_HI:RANGE_LO];
			cfg_dir   <= dir_control;
		end
	end

	assign threshold = duration_threshold(cfg_sens, cfg_range, cfg_ext);

	motion_qualifier #(
		.THR_W(THR_W),
		.RUN_W(RUN_W)
	) qualifier (
		.core_clk_i  (core_clk_i),
		.rst_i       (rst_i),
		.clear_i     (enable_event),
		.step_i      (step && !suspend_active), // detection halted
		.motion_raw_i(motion_raw_i),
		.threshold_i (threshold),
		.accept_o    (accept)
	);

	// motion sticks until software writes a zero or the engine is enabled; a new event wins over the write
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			motion    <= 1'b0;
			direction <= 1'b0;
		end else if (enable_event) begin
			motion    <= 1'b0;
			direction <= 1'b0;
		end else if (accept && !engine_disabled) begin
			motion <= 1'b1;
			if (!motion) begin
				direction <= cfg_dir && motion_dir_i; // latched with the event
			end
		end else if (wr_sc0 && !reg_wdata_i[SC0_MOTION]) begin
			motion <= 1'b0;
		end
	end

	// stability restarts on every enable
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stable <= 1'b0;
		end else if (enable_event) begin
			stable <= 1'b0;
		end else if (step) begin
			stable <= sensor_stable_i;
		end
	end

	// sampling goes on during suspend so that recovery is quick
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			adc_scan_result <= '0;
		end else if (step) begin
			adc_scan_result <= adc_data_i;
		end
	end

	always_comb begin
		next_rdata = READ_EMPTY;
		if (reg_addr_i == ENGINE_ENABLE_KEY_OFS) begin
			next_rdata = engine_enable_key;
		end else if (reg_addr_i == MOTION_SENSITIVITY_OFS) begin
			next_rdata = motion_sensitivity;
		end else if (reg_addr_i == MOTION_STATUS_CONTROL0_OFS) begin
			next_rdata = {ext_level, engine_disabled, detection_suspend,
				dir_control, direction, motion, stable};
		end else if (reg_addr_i == ENGINE_STATUS_CONTROL1_OFS) begin
			next_rdata = engine_status_control1;
		end else if (reg_addr_i == RANGE_CONTROL2_OFS) begin
			next_rdata = range_control2;
		end else if (reg_addr_i == ADC_SCAN_REQUEST3_OFS) begin
			next_rdata = adc_scan_request3;
		end else if (reg_addr_i == ADC_SCAN_RESULT_LO_OFS) begin
			next_rdata = adc_scan_result[7:0];
		end else if (reg_addr_i == ADC_SCAN_RESULT_HI_OFS) begin
			next_rdata = adc_scan_result[ADC_W-1:ADC_W-8];
		end else if (reg_addr_i == ENGINE_SOFTWARE_VERSION_OFS) begin
			next_rdata = VERSION_CODE;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= READ_EMPTY;
		end else if (reg_rd_i) begin
			reg_rdata_o <= next_rdata;
		end
	end

	assign engine_running_o   = !engine_disabled;
	assign motion_detected_o  = motion;
	assign detection_active_o = !engine_disabled && !suspend_active;

	sequence off_key_held;
		engine_enable_key == ENGINE_OFF_KEY && !engine_disabled;
	endsequence

	sequence enable_seen;
		engine_disabled && engine_enable_key == ENGINE_ON_KEY
			&& (engine_init_entry_i || adc_irq_i);
	endsequence

	key_readback_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_key ##1 !reg_wr_i
		##1 (reg_rd_i && reg_addr_i == ENGINE_ENABLE_KEY_OFS && !reg_wr_i)
		|=> reg_rdata_o == $past(reg_wdata_i, 3))
		else $error("enable register did not read back the written key");

	enable_starts_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		enable_seen |=> !engine_disabled && engine_running_o)
		else $error("on key did not start the engine");

	disable_at_irq_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		off_key_held ##0 adc_irq_i |=> engine_disabled ##1 engine_disabled)
		else $error("off key not honoured at the interrupt");

	disable_waits_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		off_key_held ##0 !adc_irq_i |=> !engine_disabled)
		else $error("engine stopped before its interrupt ran");

	reserved_key_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		engine_enable_key != ENGINE_ON_KEY && engine_enable_key != ENGINE_OFF_KEY
		|=> $stable(engine_disabled))
		else $error("reserved key changed the engine state");

	status_default_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		enable_event |=> !motion && !stable && cfg_sens == $past(motion_sensitivity))
		else $error("enable did not reset status or capture configuration");

	motion_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		motion && !enable_event && !(wr_sc0 && !reg_wdata_i[SC0_MOTION]) |=> motion)
		else $error("motion flag dropped without a software clear");

	suspend_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		suspend_active [*2] |-> !accept)
		else $error("motion accepted while suspended");

	status_ro_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		wr_sc0 && !adc_irq_i && !engine_init_entry_i |=> $stable(engine_disabled)
		&& $stable(stable))
		else $error("read-only status bits changed by a write");

	disabled_idle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		engine_disabled |=> !accept && $stable(adc_scan_result))
		else $error("disabled engine went on detecting or sampling");

	suspend_enter_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		adc_irq_i && detection_suspend |=> !detection_active_o)
		else $error("suspend not taken at the interrupt");

	motion_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
		accept && !engine_disabled |=> motion_detected_o)
		else $error("accepted motion did not set the detected flag");
endmodule
`default_nettype wire

// *** verif/motion_engine_regs_tb.sv ***
// self-checking bench for the motion engine register bank
`default_nettype none
module motion_engine_regs_tb
	import motion_engine_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [7:0] VER = 8'h5a; // arbitrary value

	logic              core_clk_i;
	logic              rst_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic              reg_wr_i;
	logic [7:0]        reg_wdata_i;
	logic              reg_rd_i;
	logic [7:0]        reg_rdata_o;
	logic              engine_init_entry_i;
	logic              adc_irq_i;
	logic [15:0]       adc_data_i;
	logic              motion_raw_i;
	logic              motion_dir_i;
	logic              sensor_stable_i;
	logic              engine_running_o;
	logic              motion_detected_o;
	logic              detection_active_o;

	int         seed = 32'he1c1add1;
	int         n_mismatch = 0;
	int         cmp_count = 0;
	int         cycles = 0;
	int         thr;
	logic       rd_q = 1'b0;
	logic       dir_bit = 1'b0;
	logic       dc;
	logic [1:0] ext;
	logic [7:0] sens;
	logic [7:0] rsv;
	logic [15:0] adc_last = 16'h0000;
	logic [7:0] exp_q[$];
	string      name_q[$];

	motion_engine_regs #(
		.VERSION_CODE(VER),
		.ADC_W       (16)
	) u_dut (
		.core_clk_i         (core_clk_i),
		.rst_i              (rst_i),
		.reg_addr_i         (reg_addr_i),
		.reg_wr_i           (reg_wr_i),
		.reg_wdata_i        (reg_wdata_i),
		.reg_rd_i           (reg_rd_i),
		.reg_rdata_o        (reg_rdata_o),
		.engine_init_entry_i(engine_init_entry_i),
		.adc_irq_i          (adc_irq_i),
		.adc_data_i         (adc_data_i),
		.motion_raw_i       (motion_raw_i),
		.motion_dir_i       (motion_dir_i),
		.sensor_stable_i    (sensor_stable_i),
		.engine_running_o   (engine_running_o),
		.motion_detected_o  (motion_detected_o),
		.detection_active_o (detection_active_o)
	);

	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// read data lands one edge after the read strobe, so compare mid-cycle
	always @(posedge core_clk_i) rd_q <= reg_rd_i;
	always @(negedge core_clk_i) begin
		if (rd_q === 1'b1) begin
			if (exp_q.size() == 0) begin
				cmp("unexpected read", 8'h00, 8'hxx);
			end else begin
				cmp(name_q.pop_front(), exp_q.pop_front(), reg_rdata_o);
			end
		end
	end

	always @(posedge core_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		exp_q.push_back(e);
		name_q.push_back(nm);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
	endtask

	task automatic step(input logic raw);
		@(posedge core_clk_i);
		adc_last = 16'($random(seed));
		adc_irq_i <= 1'b1;
		motion_raw_i <= raw;
		motion_dir_i <= dir_bit;
		adc_data_i <= adc_last;
		@(posedge core_clk_i);
		adc_irq_i <= 1'b0;
	endtask

	// status outputs follow registers; let them land before looking
	task automatic settle();
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	initial begin
		rst_i = 1'b1;
		reg_addr_i = '0;
		reg_wr_i = 1'b0;
		reg_wdata_i = 8'h00;
		reg_rd_i = 1'b0;
		engine_init_entry_i = 1'b0;
		adc_irq_i = 1'b0;
		adc_data_i = 16'h0000;
		motion_raw_i = 1'b0;
		motion_dir_i = 1'b0;
		sensor_stable_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(MOTION_STATUS_CONTROL0_OFS, 8'h20, "sc0 after reset");
		sens = 8'($random(seed)) & 8'h07;
		wr(MOTION_SENSITIVITY_OFS, sens);
		wr(RANGE_CONTROL2_OFS, 8'h08);
		rsv = 8'($random(seed));
		if (rsv == ENGINE_OFF_KEY || rsv == ENGINE_ON_KEY) rsv = 8'h5c;
		wr(ENGINE_ENABLE_KEY_OFS, rsv);
		step(1'b0);
		settle();
		cmp("running on reserved", 8'h00, {7'h0, engine_running_o});
		rd(ENGINE_ENABLE_KEY_OFS, rsv, "key readback");
		wr(ENGINE_ENABLE_KEY_OFS, ENGINE_ON_KEY);
		@(posedge core_clk_i);
		engine_init_entry_i <= 1'b1;
		@(posedge core_clk_i);
		engine_init_entry_i <= 1'b0;
		settle();
		cmp("running", 8'h01, {7'h0, engine_running_o});
		cmp("active", 8'h01, {7'h0, detection_active_o});
		rd(MOTION_STATUS_CONTROL0_OFS, 8'h00, "sc0 enabled");
		rd(ENGINE_ENABLE_KEY_OFS, ENGINE_ON_KEY, "key readback");
		// duration threshold shrinks as the extended level rises
		for (int e = 0; e < 4; e++) begin
			ext = 2'(e);
			dc = ext[0];
			dir_bit = 1'($random(seed));
			wr(MOTION_STATUS_CONTROL0_OFS, {ext, 2'b00, dc, 3'b010});
			step(1'b0);
			step(1'b0);
			thr = int'(sens) + (8 >> e) - e;
			if (thr < 0) thr = 0;
			repeat (thr) step(1'b1);
			step(1'b0);
			settle();
			cmp("motion early", 8'h00, {7'h0, motion_detected_o});
			repeat (thr + 1) step(1'b1);
			settle();
			cmp("motion", 8'h01, {7'h0, motion_detected_o});
			rd(MOTION_STATUS_CONTROL0_OFS, {ext, 2'b00, dc, dc & dir_bit, 2'b10},
				"sc0 motion");
			wr(MOTION_STATUS_CONTROL0_OFS, {ext, 6'h00});
			settle();
			cmp("motion cleared", 8'h00, {7'h0, motion_detected_o});
		end
		thr = int'(sens) + 8;
		wr(MOTION_STATUS_CONTROL0_OFS, 8'h10);
		settle();
		cmp("active before irq", 8'h01, {7'h0, detection_active_o});
		step(1'b0);
		settle();
		cmp("active suspended", 8'h00, {7'h0, detection_active_o});
		repeat (thr + 2) step(1'b1);
		settle();
		cmp("motion suspended", 8'h00, {7'h0, motion_detected_o});
		wr(MOTION_STATUS_CONTROL0_OFS, 8'h00);
		step(1'b0);
		step(1'b0);
		repeat (thr + 1) step(1'b1);
		settle();
		cmp("motion resumed", 8'h01, {7'h0, motion_detected_o});
		wr(MOTION_STATUS_CONTROL0_OFS, 8'h00);
		wr(ENGINE_STATUS_CONTROL1_OFS, 8'h80);
		rd(ENGINE_STATUS_CONTROL1_OFS, 8'h80, "tick set");
		step(1'b0);
		rd(ENGINE_STATUS_CONTROL1_OFS, 8'h00, "tick cleared");
		rd(ADC_SCAN_RESULT_LO_OFS, adc_last[7:0], "adc lo");
		rd(ADC_SCAN_RESULT_HI_OFS, adc_last[15:8], "adc hi");
		wr(ENGINE_SOFTWARE_VERSION_OFS, 8'hff);
		rd(ENGINE_SOFTWARE_VERSION_OFS, VER, "version");
		wr(ADC_SCAN_REQUEST3_OFS, 8'ha5);
		rd(ADC_SCAN_REQUEST3_OFS, 8'ha5, "scan request");
		wr(12'h1ff, 8'h77);
		rd(12'h1ff, READ_EMPTY, "unmapped");
		wr(ENGINE_ENABLE_KEY_OFS, rsv);
		step(1'b0);
		settle();
		cmp("running reserved", 8'h01, {7'h0, engine_running_o});
		wr(ENGINE_ENABLE_KEY_OFS, ENGINE_OFF_KEY);
		rd(ENGINE_ENABLE_KEY_OFS, ENGINE_OFF_KEY, "off key readback");
		settle();
		cmp("running before irq", 8'h01, {7'h0, engine_running_o});
		step(1'b0);
		settle();
		cmp("running off", 8'h00, {7'h0, engine_running_o});
		rd(MOTION_STATUS_CONTROL0_OFS, 8'h20, "sc0 disabled");
		repeat (thr + 2) step(1'b1);
		settle();
		cmp("motion disabled", 8'h00, {7'h0, motion_detected_o});
		rd(ENGINE_ENABLE_KEY_OFS, ENGINE_OFF_KEY, "key readback");
		settle();
		conclude();
	end
endmodule
`default_nettype wire
